// *** bench/host_port_model.sv ***
/*
 Host CPU model on the data port: sends queued transfers under the ready handshake.
 Assumes the bench fills q and that ready is sampled at the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module host_port_model
	import pbuf_pkg::*;
(
	// Clock and handshake
	input  wire logic        clk_i,
	input  wire logic        port_ready_i,
	input  wire logic        word_mode_i,
	// Data port drive
	output var  logic        port_write_o,
	output var  logic [15:0] port_data_o
);
	logic [15:0] q[$];
	logic [15:0] last = 16'h0000;
	logic        taken;
	initial begin
		port_write_o = 1'b0;
		port_data_o = 16'hffff;
	end
	// Request is held until ready is seen high at an edge
	always @(posedge clk_i) begin
		taken = port_write_o & port_ready_i;
		if (taken)
			void'(q.pop_front());
		#1;
		// Word mode needs a free cycle after each word
		if (q.size() != 0 && !(taken && word_mode_i)) begin
			port_write_o <= 1'b1;
			port_data_o <= q[0];
			last = q[0];
		end else begin
			port_write_o <= 1'b0;
			port_data_o <= ~last;
		end
	end
endmodule
`default_nettype wire

// *** bench/packet_buffer_dma_tb.sv ***
/*
 Testbench for packet_buffer_dma: host model on the data port, memory model, MAC stimulus.
 Assumes pbuf_pkg, the design and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module packet_buffer_dma_tb
	import pbuf_pkg::*;
;
	logic        clk_i = 1'b0, reset_i, clk_en_i, accept_errored_i, remote_write_go_i, tx_go_bit_i;
	logic        rx_start_i, rx_byte_valid_i, rx_end_i, ipg_done_i, backoff_done_i, collision_i;
	logic        tx_done_i, tx_fifo_ready_i, port_write_i, tx_fifo_valid_o, tx_fifo_flush_o, tx_start_o;
	logic        port_ready_o, mem_we_o, mem_re_o, rx_overflow_o, remote_busy_o;
	logic [7:0]  tx_start_page_i, tx_count_low_i, tx_count_high_i, remote_start_low_i, remote_start_high_i;
	logic [7:0]  remote_count_low_i, remote_count_high_i, rx_byte_i, tx_fifo_data_o, mem_wdata_o;
	logic [7:0]  mem_rdata_i, current_page_pointer_o, tx_status_o, mem[0:65535], fq[$];
	logic [15:0] port_data_i, mem_addr_o;
	logic [3:0]  collision_tally_o;
	logic [23:0] wq[$];
	port_cfg_t   port_cfg_i;
	ring_cfg_t   ring_cfg_i;
	rx_end_t     rx_end_info_i;
	int          fails = 0, n_compared = 0;

	packet_buffer_dma u_dut(.clk_i, .reset_i, .clk_en_i, .port_cfg_i, .ring_cfg_i, .accept_errored_i,
		.tx_start_page_i, .tx_count_low_i, .tx_count_high_i, .remote_start_low_i, .remote_start_high_i,
		.remote_count_low_i, .remote_count_high_i, .remote_write_go_i, .tx_go_bit_i, .rx_start_i,
		.rx_byte_valid_i, .rx_byte_i, .rx_end_i, .rx_end_info_i, .ipg_done_i, .backoff_done_i, .collision_i,
		.tx_done_i, .tx_fifo_ready_i, .tx_fifo_valid_o, .tx_fifo_data_o, .tx_fifo_flush_o, .tx_start_o,
		.port_write_i, .port_data_i, .port_ready_o, .mem_we_o, .mem_re_o, .mem_addr_o, .mem_wdata_o,
		.mem_rdata_i, .current_page_pointer_o, .tx_status_o, .collision_tally_o, .rx_overflow_o, .remote_busy_o);
	host_port_model u_host(.clk_i, .port_ready_i(port_ready_o), .word_mode_i(port_cfg_i.word_transfer_select),
		.port_write_o(port_write_i), .port_data_o(port_data_i));

	initial forever #2.5 clk_i = ~clk_i;
	// Buffer memory with one-cycle read latency; every write is logged
	always @(posedge clk_i) begin
		if (mem_we_o === 1'b1) begin
			mem[mem_addr_o] <= mem_wdata_o;
			wq.push_back({mem_addr_o, mem_wdata_o});
		end
		mem_rdata_i <= mem[mem_addr_o];
		if (tx_fifo_valid_o === 1'b1 && tx_fifo_ready_i)
			fq.push_back(tx_fifo_data_o);
	end

	task automatic tally_and_finish;
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [23:0] e;
		e = wq.size() != 0 ? wq.pop_front() : 24'hx;
		check(e, {a, d});
	endtask
	task automatic remote(input logic [15:0] a, input logic [15:0] n, input logic w, input logic b,
		input logic [15:0] d[$]);
		port_cfg_i = '{b, w, 1'b1};
		{remote_start_high_i, remote_start_low_i} = a;
		{remote_count_high_i, remote_count_low_i} = n;
		remote_write_go_i = 1'b1;
		tick(1);
		remote_write_go_i = 1'b0;
		foreach (d[i]) u_host.q.push_back(d[i]);
		for (int i = 0; i < 300 && (remote_busy_o !== 1'b0 || u_host.q.size() != 0); i++) tick(1);
		check(remote_busy_o, 0);
	endtask
	task automatic pulse_go;
		tx_go_bit_i = 1'b1;
		tick(1);
		tx_go_bit_i = 1'b0;
	endtask
	task automatic rx_frame(input logic [7:0] d[$], input rx_end_t info);
		rx_start_i = 1'b1;
		tick(1);
		rx_start_i = 1'b0;
		foreach (d[i]) begin
			rx_byte_valid_i = 1'b1;
			rx_byte_i = d[i];
			tick(1);
		end
		rx_byte_valid_i = 1'b0;
		rx_end_i = 1'b1;
		rx_end_info_i = info;
		tick(1);
		rx_end_i = 1'b0;
		tick(12);
	endtask

	initial begin
		#100000;
		fails++;
		tally_and_finish;
	end
	initial begin
		{reset_i, clk_en_i, backoff_done_i} = 3'b111;
		{accept_errored_i, remote_write_go_i, tx_go_bit_i, rx_start_i, rx_byte_valid_i, rx_end_i} = 6'h00;
		{ipg_done_i, collision_i, tx_done_i, tx_fifo_ready_i, rx_byte_i, rx_end_info_i} = '0;
		{tx_start_page_i, tx_count_low_i, tx_count_high_i, remote_start_low_i, remote_start_high_i} = '0;
		{remote_count_low_i, remote_count_high_i} = 16'h0000;
		port_cfg_i = '{1'b0, 1'b0, 1'b1};
		ring_cfg_i = '{8'h00, 8'h20, 8'h1f};
		tick(2);
		reset_i = 1'b0;
		check(tx_status_o, 0);
		remote(16'h0200, 16'h0003, 1'b0, 1'b0, '{16'h0011, 16'h0022, 16'h0033});
		wr(16'h0200, 8'h11);
		wr(16'h0201, 8'h22);
		wr(16'h0202, 8'h33);
		for (int b = 0; b < 2; b++) begin
			remote(16'h0300, 16'h0004, 1'b1, b[0], '{16'hbbaa, 16'hddcc});
			wr(16'h0300, b ? 8'hbb : 8'haa);
			wr(16'h0301, b ? 8'haa : 8'hbb);
			wr(16'h0302, b ? 8'hdd : 8'hcc);
			wr(16'h0303, b ? 8'hcc : 8'hdd);
		end
		// Transmit three bytes from page 2, holding the MAC off first
		tx_start_page_i = 8'h02;
		{tx_count_high_i, tx_count_low_i} = 16'h0003;
		pulse_go;
		tick(8);
		check(tx_start_o, 0);
		ipg_done_i = 1'b1;
		#1 check(tx_start_o, 1);
		backoff_done_i = 1'b0;
		#1 check(tx_start_o, 0);
		backoff_done_i = 1'b1;
		tx_fifo_ready_i = 1'b1;
		tick(20);
		check(fq.size(), 3);
		foreach (fq[i]) check(fq[i], 8'h11 * (i + 1));
		tx_done_i = 1'b1;
		tick(1);
		tx_done_i = 1'b0;
		tick(1);
		check(tx_status_o[TSR_PTX_BIT], 1);
		pulse_go;
		tick(2);
		check(tx_status_o, STATUS_CLEAR);
		for (int i = 1; i <= 15; i++) begin
			collision_i = 1'b1;
			#1 check(tx_fifo_flush_o, 1);
			tick(1);
			collision_i = 1'b0;
			tick(4);
			check(collision_tally_o, i[3:0]);
			check(tx_status_o[TSR_ABT_BIT], i == 15);
		end
		check(tx_status_o[TSR_COL_BIT], 1);
		// Good frame, then a rejected one, then a good one on the recovered page
		rx_frame('{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55}, '{1'b1, 1'b0, 1'b0, 1'b0, 8'h01});
		for (int i = 0; i < 6; i++) wr(16'h0004 + i, 8'h50 + i);
		wr(16'h0000, 8'h01);
		wr(16'h0001, 8'h01);
		wr(16'h0002, 8'h06);
		wr(16'h0003, 8'h00);
		check(current_page_pointer_o, 8'h01);
		rx_frame('{8'h60, 8'h61, 8'h62}, '{1'b0, 1'b0, 1'b1, 1'b0, 8'h02});
		wq.delete();
		check(current_page_pointer_o, 8'h01);
		rx_frame('{8'h70, 8'h71}, '{1'b1, 1'b0, 1'b0, 1'b0, 8'h01});
		wr(16'h0104, 8'h70);
		wr(16'h0105, 8'h71);
		wr(16'h0100, 8'h01);
		wr(16'h0101, 8'h02);
		wr(16'h0102, 8'h02);
		wr(16'h0103, 8'h00);
		check(current_page_pointer_o, 8'h02);
		// Errored frame kept when errored frames are accepted
		accept_errored_i = 1'b1;
		rx_frame('{8'h80}, '{1'b1, 1'b0, 1'b1, 1'b0, 8'h02});
		wr(16'h0204, 8'h80);
		wr(16'h0200, 8'h02);
		wr(16'h0201, 8'h03);
		wr(16'h0202, 8'h01);
		wr(16'h0203, 8'h00);
		check(current_page_pointer_o, 8'h03);
		tally_and_finish;
	end
endmodule
`default_nettype wire

// *** include/pbuf_pkg.sv ***
/*
 Shared constants and carrier types for the packet buffer DMA block.
 Assumes a single 200 MHz device clock and an 8-bit byte-wide buffer memory.
*/
package pbuf_pkg;
	localparam int  ADDR_W      = 16;
	localparam int  PAGE_W      = 8;
	localparam int  CNT_W       = 16;
	localparam int  PAGE_LSB_W  = 8;
	localparam logic [PAGE_LSB_W-1:0] PAGE_LOW = 8'h00;
	localparam logic [3:0] MAX_RETRY = 4'hf;
	localparam logic [ADDR_W-1:0] HDR_BYTES = 16'h0004;
	localparam logic [7:0] STATUS_CLEAR = 8'h00;
	localparam int  TSR_COL_BIT = 2;
	localparam int  TSR_ABT_BIT = 3;
	localparam int  TSR_PTX_BIT = 0;

	// Host port configuration
	typedef struct packed {
		logic byte_order_select;
		logic word_transfer_select;
		logic cpu_wide;
	} port_cfg_t;

	// Receive end-of-frame report from the MAC receive logic
	typedef struct packed {
		logic       good;
		logic       runt;
		logic       crc_err;
		logic       align_err;
		logic [7:0] rx_status;
	} rx_end_t;

	// Ring setup
	typedef struct packed {
		logic [PAGE_W-1:0] ring_first_page;
		logic [PAGE_W-1:0] ring_end_page;
		logic [PAGE_W-1:0] read_boundary_page;
	} ring_cfg_t;
endpackage

// *** verilog/packet_buffer_dma.sv ***
/*
 Packet buffer DMA: receive end-of-frame handling, transmit local DMA read
 with collision retry, and the remote DMA write channel from the host port.
 Assumes the MAC supplies byte strobes and collision events on clk_i, and
 that the buffer memory accepts one write or read per cycle without a grant.
*/
// Functional notes
// - Good frame: write header at first page.
// - Next frame starts at next free page.
// - Load current page from scratch next page.
// - Bad frame resets DMA to current page.
// - Skip recovery when accepting errored frames; the code still recovers any frame whose good flag is low.
// - Store received FCS after last data byte.
// - Transmit reads from start page, count bytes.
// - MAC adds preamble, delimiter and FCS.
// - Transmit count excludes preamble and FCS.
// - Port transfer is word or byte wide.
// - Go bit clears status, starts prefetch.
// - Start needs gap, FIFO byte, backoff done.
// - Collision flushes, rewinds, flags, counts.
// - Fifteen collisions abandon the frame.
// - Little-endian word: even byte low lane.
// - Big-endian word: even byte high lane.
// - Byte mode: one byte per access, in order.
// - Wire order from first destination byte.
// - Remote start and count from register pairs.
// - Remote write: store, increment, decrement, stop.
// - Data port uses full ready handshake.
// - Next page at ring end wraps to first.
// - Next page at boundary aborts reception.
`timescale 1ns/100ps
`default_nettype none
module packet_buffer_dma
	import pbuf_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              clk_en_i,
	// Configuration
	input  wire port_cfg_t         port_cfg_i,
	input  wire ring_cfg_t         ring_cfg_i,
	input  wire logic              accept_errored_i,
	input  wire logic [PAGE_W-1:0] tx_start_page_i,
	input  wire logic [7:0]        tx_count_low_i,
	input  wire logic [7:0]        tx_count_high_i,
	input  wire logic [7:0]        remote_start_low_i,
	input  wire logic [7:0]        remote_start_high_i,
	input  wire logic [7:0]        remote_count_low_i,
	input  wire logic [7:0]        remote_count_high_i,
	input  wire logic              remote_write_go_i,
	input  wire logic              tx_go_bit_i,
	// Receive side from MAC
	input  wire logic              rx_start_i,
	input  wire logic              rx_byte_valid_i,
	input  wire logic [7:0]        rx_byte_i,
	input  wire logic              rx_end_i,
	input  wire rx_end_t           rx_end_info_i,
	// Transmit side to and from MAC
	input  wire logic              ipg_done_i,
	input  wire logic              backoff_done_i,
	input  wire logic              collision_i,
	input  wire logic              tx_done_i,
	input  wire logic              tx_fifo_ready_i,
	output logic                   tx_fifo_valid_o,
	output logic [7:0]             tx_fifo_data_o,
	output logic                   tx_fifo_flush_o,
	output logic                   tx_start_o,
	// Host data port
	input  wire logic              port_write_i,
	input  wire logic [15:0]       port_data_i,
	output logic                   port_ready_o,
	// Buffer memory
	output logic                   mem_we_o,
	output logic                   mem_re_o,
	output logic [ADDR_W-1:0]      mem_addr_o,
	output logic [7:0]             mem_wdata_o,
	input  wire logic [7:0]        mem_rdata_i,
	// Status
	output logic [PAGE_W-1:0]      current_page_pointer_o,
	output logic [7:0]             tx_status_o,
	output logic [3:0]             collision_tally_o,
	output logic                   rx_overflow_o,
	output logic                   remote_busy_o
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] page_addr(input logic [PAGE_W-1:0] p);
		page_addr = {p, PAGE_LOW};
	endfunction

	function automatic logic [PAGE_W-1:0] wrap_page(input logic [PAGE_W-1:0] p,
							input ring_cfg_t r);
		wrap_page = (p == r.ring_end_page) ? r.ring_first_page : p;
	endfunction

	typedef enum {RX_IDLE, RX_STORE, RX_HDR} rx_state_t;
	typedef enum {TX_IDLE, TX_FETCH, TX_DONE} tx_state_t;

	rx_state_t         rx_state;
	logic [ADDR_W-1:0] rx_addr;
	logic [CNT_W-1:0]  rx_count;
	logic [PAGE_W-1:0] scratch_page;
	logic [1:0]        hdr_idx;
	logic [7:0]        rx_stat_q;

	tx_state_t         tx_state;
	logic [ADDR_W-1:0] tx_addr;
	logic [CNT_W-1:0]  tx_left;
	logic              tx_rd_pend;

	logic [ADDR_W-1:0] rem_addr;
	logic [CNT_W-1:0]  rem_left;
	logic              rem_hi_pend;
	logic [7:0]        rem_hi_byte;

	// ---------------------------------------------------------------
	// Receive storage and end-of-frame handling
	// ---------------------------------------------------------------
	wire logic [PAGE_W-1:0] rx_next_raw  = rx_addr[ADDR_W-1:PAGE_LSB_W] + 8'h01;
	wire logic [PAGE_W-1:0] rx_next_page = wrap_page(rx_next_raw, ring_cfg_i);
	wire logic              rx_page_end  = rx_addr[PAGE_LSB_W-1:0] == 8'hff;
	wire logic              rx_hits_read_boundary_page = rx_next_page == ring_cfg_i.read_boundary_page;
	wire logic              rx_reject    = (rx_end_info_i.runt | rx_end_info_i.crc_err |
					 rx_end_info_i.align_err) & ~accept_errored_i;
	wire logic              rx_wr        = rx_state == RX_STORE && rx_byte_valid_i;
	wire logic              hdr_wr       = rx_state == RX_HDR;
	// Free page after the frame's last byte: partial last page is abandoned
	wire logic [PAGE_W-1:0] rx_free_page = wrap_page(rx_addr[ADDR_W-1:PAGE_LSB_W] + 8'h01,
						ring_cfg_i);
	wire logic [ADDR_W-1:0] hdr_base     = page_addr(current_page_pointer_o);
	wire logic [7:0]        hdr_byte     = (hdr_idx == 2'd0) ? rx_stat_q :
					(hdr_idx == 2'd1) ? scratch_page :
					(hdr_idx == 2'd2) ? rx_count[7:0] : rx_count[15:8];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_state               <= RX_IDLE;
			rx_addr                <= '0;
			rx_count               <= '0;
			scratch_page           <= '0;
			hdr_idx                <= '0;
			rx_stat_q              <= '0;
			current_page_pointer_o <= '0;
			rx_overflow_o          <= 1'b0;
		end else if (clk_en_i) begin
			case (rx_state)
				RX_IDLE: begin
					if (rx_start_i) begin
						rx_addr  <= page_addr(current_page_pointer_o) + HDR_BYTES;
						rx_count <= '0;
						rx_state <= RX_STORE;
					end
				end
				RX_STORE: begin
					// FCS bytes arrive as ordinary bytes and are stored in line
					if (rx_byte_valid_i) begin
						rx_count <= rx_count + 16'h0001;
						if (rx_page_end && rx_hits_read_boundary_page) begin
							rx_overflow_o <= 1'b1;
							rx_state      <= RX_IDLE;
						end else if (rx_page_end)
							rx_addr <= page_addr(rx_next_page);
						else
							rx_addr <= rx_addr + 16'h0001;
					end
					if (rx_end_i) begin
						if (rx_reject || !rx_end_info_i.good) begin
							// Pointer never moved, so every page of the frame is free again
							rx_addr  <= page_addr(current_page_pointer_o);
							rx_state <= RX_IDLE;
						end else begin
							scratch_page <= rx_free_page;
							rx_stat_q    <= rx_end_info_i.rx_status;
							hdr_idx      <= '0;
							rx_state     <= RX_HDR;
						end
					end
				end
				RX_HDR: begin
					hdr_idx <= hdr_idx + 2'd1;
					if (hdr_idx == 2'd3) begin
						current_page_pointer_o <= scratch_page;
						rx_state               <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Transmit local DMA read
	// ---------------------------------------------------------------
	wire logic [CNT_W-1:0] tx_total = {tx_count_high_i, tx_count_low_i};
	wire logic             tx_fetch = tx_state == TX_FETCH && tx_left != '0 && !tx_rd_pend &&
					!tx_fifo_valid_o && !rx_wr && !hdr_wr;
	wire logic             retry_out = collision_i && collision_tally_o == MAX_RETRY - 4'h1;

	// MAC serialises LSB first and adds preamble, delimiter and FCS
	assign tx_start_o = tx_state == TX_FETCH && ipg_done_i && backoff_done_i &&
			    tx_fifo_valid_o;
	assign tx_fifo_flush_o = tx_state == TX_FETCH && collision_i;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_state          <= TX_IDLE;
			tx_addr           <= '0;
			tx_left           <= '0;
			tx_rd_pend        <= 1'b0;
			tx_fifo_valid_o   <= 1'b0;
			tx_fifo_data_o    <= '0;
			tx_status_o       <= STATUS_CLEAR;
			collision_tally_o <= '0;
		end else if (clk_en_i) begin
			tx_rd_pend <= tx_fetch;
			if (tx_rd_pend) begin
				tx_fifo_valid_o <= 1'b1;
				tx_fifo_data_o  <= mem_rdata_i;
			end else if (tx_fifo_valid_o && tx_fifo_ready_i)
				tx_fifo_valid_o <= 1'b0;
			if (tx_fetch) begin
				tx_addr <= tx_addr + 16'h0001;
				tx_left <= tx_left - 16'h0001;
			end
			case (tx_state)
				TX_IDLE: begin
					if (tx_go_bit_i) begin
						tx_status_o       <= STATUS_CLEAR;
						collision_tally_o <= '0;
						tx_addr           <= page_addr(tx_start_page_i);
						tx_left           <= tx_total;
						tx_state          <= TX_FETCH;
					end
				end
				TX_FETCH: begin
					if (collision_i) begin
						tx_fifo_valid_o           <= 1'b0;
						tx_rd_pend                <= 1'b0;
						tx_addr                   <= page_addr(tx_start_page_i);
						tx_left                   <= tx_total;
						tx_status_o[TSR_COL_BIT]  <= 1'b1;
						collision_tally_o         <= collision_tally_o + 4'h1;
						if (retry_out) begin
							tx_status_o[TSR_ABT_BIT] <= 1'b1;
							tx_state                 <= TX_DONE;
						end
					end else if (tx_done_i) begin
						tx_status_o[TSR_PTX_BIT] <= 1'b1;
						tx_state                 <= TX_DONE;
					end
				end
				TX_DONE: tx_state <= TX_IDLE;
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Remote DMA write from the host data port
	// ---------------------------------------------------------------
	wire logic       word_mode = port_cfg_i.word_transfer_select & port_cfg_i.cpu_wide;
	wire logic       rem_busy  = rem_left != '0;
	// Even frame byte sits on the lane chosen by byte order
	wire logic [7:0] even_byte = port_cfg_i.byte_order_select ? port_data_i[15:8]
				   : port_data_i[7:0];
	wire logic [7:0] odd_byte  = port_cfg_i.byte_order_select ? port_data_i[7:0]
				   : port_data_i[15:8];
	// Local receive traffic has priority; the host simply waits on ready
	// Ready drops while frozen so the host never hands over a word that is not stored
	assign port_ready_o = clk_en_i && rem_busy && !rem_hi_pend && !rx_wr && !hdr_wr;
	wire logic       take      = port_ready_o && port_write_i;
	wire logic       rem_wr    = take || (rem_hi_pend && !rx_wr && !hdr_wr);
	assign remote_busy_o = rem_busy;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rem_addr    <= '0;
			rem_left    <= '0;
			rem_hi_pend <= 1'b0;
			rem_hi_byte <= '0;
		end else if (clk_en_i) begin
			if (remote_write_go_i && !rem_busy) begin
				rem_addr <= {remote_start_high_i, remote_start_low_i};
				rem_left <= {remote_count_high_i, remote_count_low_i};
			end else if (rem_wr) begin
				rem_addr <= rem_addr + 16'h0001;
				rem_left <= rem_left - 16'h0001;
				// Odd byte of a word follows; an odd final count drops it
				rem_hi_pend <= take && word_mode && rem_left != 16'h0001;
				if (take)
					rem_hi_byte <= odd_byte;
			end
		end
	end

	// ---------------------------------------------------------------
	// Memory port mux
	// ---------------------------------------------------------------
	assign mem_we_o    = clk_en_i && (rx_wr || hdr_wr || rem_wr);
	assign mem_re_o    = clk_en_i && tx_fetch;
	assign mem_addr_o  = rx_wr ? rx_addr : hdr_wr ? hdr_base + {14'h0000, hdr_idx} :
			     rem_wr ? rem_addr : tx_addr;
	assign mem_wdata_o = rx_wr ? rx_byte_i : hdr_wr ? hdr_byte :
			     rem_hi_pend ? rem_hi_byte : even_byte;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_take;
		port_ready_o && port_write_i;
	endsequence
	sequence s_word_take;
		s_take ##0 (word_mode && rem_left != 16'h0001);
	endsequence
	chk_hdr_commit: assert property (@(posedge clk_i) disable iff (reset_i)
		rx_state == RX_HDR && hdr_idx == 2'd3 && clk_en_i |=> current_page_pointer_o == $past(scratch_page))
		else $error("page pointer not loaded from scratch");
	chk_col_flush: assert property (@(posedge clk_i) disable iff (reset_i)
		tx_state == TX_FETCH && collision_i && clk_en_i |=> !tx_fifo_valid_o && tx_status_o[TSR_COL_BIT])
		else $error("collision did not flush and flag");
	chk_start_gate: assert property (@(posedge clk_i) disable iff (reset_i)
		tx_start_o |-> ipg_done_i && backoff_done_i && tx_fifo_valid_o)
		else $error("transmit start without all conditions");
	chk_go_clears: assert property (@(posedge clk_i) disable iff (reset_i)
		tx_state == TX_IDLE && tx_go_bit_i && clk_en_i |=> tx_status_o == STATUS_CLEAR && collision_tally_o == 4'h0)
		else $error("go bit did not clear status");
	chk_remote_step: assert property (@(posedge clk_i) disable iff (reset_i)
		s_take |=> rem_left == $past(rem_left) - 16'h0001)
		else $error("remote count did not step");
	chk_word_pair: assert property (@(posedge clk_i) disable iff (reset_i)
		s_word_take |=> rem_hi_pend && !port_ready_o)
		else $error("odd byte of word not pending");
endmodule
`default_nettype wire
